// ===== verilog/spx_core.sv
/*
 Scratchpad addressing: decodes the 4-bit register operand into a
 scratchpad location, keeps the six-bit index register, updates its low
 field after D and E accesses, and gives 16-bit pair access.
 Assumes the decoder raises one access strobe per cycle at most.
*/
`timescale 1ns/1ps

// How it works
// RQ1: Six-bit index register, low and high three-bit fields each loadable alone.
// RQ2: Operand 0 to B selects the scratchpad byte at that same location.
// RQ3: Operand C addresses through the index register, which stays unchanged.
// RQ4: Operand D addresses through the index, then low field plus one.
// RQ5: Low field wraps modulo eight; high field never changes on stepping.
// RQ6: Bytes 10 and 11 form pair H, moved as one unit.
// RQ7: Bytes 12 upper and 13 lower form pair K, halves separately selectable.
// RQ8: Bytes 14 upper and 15 lower form pair Q, halves separately selectable.
// RQ9: Operand E addresses through the index, then low field minus one.
// RQ10: Decoder never issues operand F; it is flagged and ignored here.
module spx_core
   import spx_pkg::*;
#(
   parameter int DATA_W = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Byte access by register operand
   input wire logic acc_en,
   input wire logic acc_write,
   input wire logic [3:0] acc_reg,
   input wire logic [DATA_W-1:0] acc_wdata,
   output logic [DATA_W-1:0] acc_rdata,
   output logic acc_valid,
   output logic acc_illegal,
   // Pair access
   input wire logic pair_en,
   input wire logic pair_write,
   input wire spx_pkg::spx_pair_t pair_sel,
   input wire logic [2*DATA_W-1:0] pair_wdata,
   output logic [2*DATA_W-1:0] pair_rdata,
   output logic pair_valid,
   // Index register loads
   input wire logic index_load,
   input wire logic index_low_load,
   input wire logic index_high_load,
   input wire logic [5:0] index_wdata,
   output logic [5:0] scratch_index_reg
);
   import spx_pkg::*;

   // ==========================================================
   // State
   typedef struct packed {
      logic [2:0] index_high_bits;
      logic [2:0] index_low_bits;
      logic acc_valid;
      logic acc_illegal;
      logic pair_valid;
      logic pair_wr_pend;
      logic [5:0] pair_wr_addr;
      logic [DATA_W-1:0] pair_wr_lo;
   } spx_state_t;

   spx_state_t st;
   spx_state_t next_st;

   logic [5:0] acc_addr;
   logic acc_legal;
   logic [5:0] pair_upper;
   logic ram_wr_en;
   logic [5:0] ram_wr_addr;
   logic [DATA_W-1:0] ram_wr_data;
   logic [5:0] rd_addr_a;
   logic [5:0] rd_addr_b;
   logic [DATA_W-1:0] rd_data_a;
   logic [DATA_W-1:0] rd_data_b;

   // ==========================================================
   // Address decode
   always_comb begin
      acc_legal = (acc_reg != SPX_OP_ILLEGAL); // see RQ10
      if (acc_reg <= SPX_OP_DIRECT_MAX) begin
         acc_addr = {2'b00, acc_reg}; // see RQ2
      end else begin
         acc_addr = {st.index_high_bits, st.index_low_bits}; // see RQ3
      end
      case (pair_sel)
         SPX_PAIR_H: pair_upper = SPX_LOC_H_UPPER; // see RQ6
         SPX_PAIR_K: pair_upper = SPX_LOC_K_UPPER; // see RQ7
         SPX_PAIR_Q: pair_upper = SPX_LOC_Q_UPPER; // see RQ8
         default: pair_upper = SPX_LOC_H_UPPER;
      endcase
   end

   // ==========================================================
   // Store ports
   // A pair write takes two cycles on the single write port; the low
   // byte lands one cycle after the upper one.
   always_comb begin
      ram_wr_en = 1'b0;
      ram_wr_addr = acc_addr;
      ram_wr_data = acc_wdata;
      if (st.pair_wr_pend) begin
         ram_wr_en = 1'b1;
         ram_wr_addr = st.pair_wr_addr;
         ram_wr_data = st.pair_wr_lo;
      end else if (pair_en && pair_write && pair_sel != SPX_PAIR_NONE) begin
         ram_wr_en = 1'b1;
         ram_wr_addr = pair_upper;
         ram_wr_data = pair_wdata[2*DATA_W-1:DATA_W]; // see RQ6
      end else if (acc_en && acc_write && acc_legal) begin
         ram_wr_en = 1'b1;
      end
      rd_addr_a = pair_en ? pair_upper : acc_addr;
      rd_addr_b = pair_upper + 6'h01; // see RQ7
   end

   spx_ram #(
      .DATA_W(DATA_W),
      .ADDR_W(SPX_ADDR_W),
      .DEPTH(SPX_DEPTH)
   ) u_ram (
      .clock(clock),
      .wr_en(ram_wr_en),
      .wr_addr(ram_wr_addr),
      .wr_data(ram_wr_data),
      .rd_addr_a(rd_addr_a),
      .rd_data_a(rd_data_a),
      .rd_addr_b(rd_addr_b),
      .rd_data_b(rd_data_b)
   );

   // ==========================================================
   // Next state
   always_comb begin
      next_st = st;
      next_st.acc_valid = acc_en && !acc_write && !pair_en && acc_legal;
      next_st.acc_illegal = acc_en && !acc_legal;
      next_st.pair_valid = pair_en && !pair_write && pair_sel != SPX_PAIR_NONE;
      next_st.pair_wr_pend = pair_en && pair_write && pair_sel != SPX_PAIR_NONE
         && !st.pair_wr_pend;
      next_st.pair_wr_addr = pair_upper + 6'h01;
      next_st.pair_wr_lo = pair_wdata[DATA_W-1:0];
      if (acc_en && acc_legal) begin
         if (acc_reg == SPX_OP_INDEX_INC) begin
            next_st.index_low_bits = st.index_low_bits + SPX_FIELD_ONE; // see RQ4 RQ5
         end else if (acc_reg == SPX_OP_INDEX_DEC) begin
            next_st.index_low_bits = st.index_low_bits - SPX_FIELD_ONE; // see RQ9 RQ5
         end
      end
      // Explicit loads override the post-access step
      if (index_load) begin
         next_st.index_high_bits = index_wdata[5:3]; // see RQ1
         next_st.index_low_bits = index_wdata[2:0];
      end else begin
         if (index_high_load) begin
            next_st.index_high_bits = index_wdata[5:3]; // see RQ1
         end
         if (index_low_load) begin
            next_st.index_low_bits = index_wdata[2:0]; // see RQ1
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Outputs
   always_comb begin
      acc_rdata = rd_data_a;
      pair_rdata = {rd_data_a, rd_data_b};
      acc_valid = st.acc_valid;
      acc_illegal = st.acc_illegal;
      pair_valid = st.pair_valid;
      scratch_index_reg = {st.index_high_bits, st.index_low_bits};
   end

   // ==========================================================
   // Checks
   sequence s_step_access;
      acc_en && acc_legal && !index_load && !index_low_load;
   endsequence

   // A high-field load in the same cycle is a separate instruction, not a C side effect
   a_index_hold_c: assert property (@(posedge clock) disable iff (rst) // see RQ3
      (s_step_access and acc_reg == SPX_OP_INDEX && !index_high_load) |=>
      $stable(scratch_index_reg)) else $error("index changed after C access");

   a_index_inc_d: assert property (@(posedge clock) disable iff (rst) // see RQ4
      (s_step_access and acc_reg == SPX_OP_INDEX_INC) |=>
      scratch_index_reg[2:0] == $past(scratch_index_reg[2:0]) + 3'h1)
      else $error("low field not stepped up");

   a_index_dec_e: assert property (@(posedge clock) disable iff (rst) // see RQ9
      (s_step_access and acc_reg == SPX_OP_INDEX_DEC) |=>
      scratch_index_reg[2:0] == $past(scratch_index_reg[2:0]) - 3'h1)
      else $error("low field not stepped down");

   a_high_field_kept: assert property (@(posedge clock) disable iff (rst) // see RQ5
      (!index_load && !index_high_load) |=>
      scratch_index_reg[5:3] == $past(scratch_index_reg[5:3]))
      else $error("high field moved without load");

   // Checked at the store port so the write mux is covered as well as the decode
   a_direct_addr_map: assert property (@(posedge clock) disable iff (rst) // see RQ2
      (acc_en && acc_write && acc_reg <= SPX_OP_DIRECT_MAX && !pair_en && !st.pair_wr_pend)
      |-> ram_wr_en && ram_wr_addr == {2'b00, acc_reg})
      else $error("direct operand misaddressed");

   a_field_load_low: assert property (@(posedge clock) disable iff (rst) // see RQ1
      (index_low_load && !index_load) |=>
      scratch_index_reg[2:0] == $past(index_wdata[2:0]))
      else $error("low field load lost");

   a_pair_k_addr: assert property (@(posedge clock) disable iff (rst) // see RQ7
      (pair_en && pair_sel == SPX_PAIR_K) |-> rd_addr_b == SPX_LOC_K_LOWER)
      else $error("pair K lower byte misplaced");

   a_pair_q_addr: assert property (@(posedge clock) disable iff (rst) // see RQ8
      (pair_en && pair_sel == SPX_PAIR_Q) |-> rd_addr_a == SPX_LOC_Q_UPPER)
      else $error("pair Q upper byte misplaced");

   a_pair_h_write: assert property (@(posedge clock) disable iff (rst) // see RQ6
      (pair_en && pair_write && pair_sel == SPX_PAIR_H && !st.pair_wr_pend) |=>
      ram_wr_en && ram_wr_addr == SPX_LOC_H_LOWER)
      else $error("pair H low byte not written");

   a_illegal_flag: assert property (@(posedge clock) disable iff (rst) // see RQ10
      (acc_en && acc_reg == SPX_OP_ILLEGAL) |=> acc_illegal && !acc_valid)
      else $error("operand F not flagged");
endmodule

// ===== verilog/spx_pkg.sv
/*
 Package for the scratchpad addressing block: operand codes, pair
 locations, widths and reset values.
 Assumes one clock domain and a synchronous active-high reset.
*/
package spx_pkg;
   // ==========================================================
   // Widths
   localparam int SPX_DATA_W = 8;
   localparam int SPX_ADDR_W = 6;
   localparam int SPX_FIELD_W = 3;
   localparam int SPX_DEPTH = 64;
   // ==========================================================
   // Register operand codes
   localparam logic [3:0] SPX_OP_DIRECT_MAX = 4'hB;
   localparam logic [3:0] SPX_OP_INDEX = 4'hC;
   localparam logic [3:0] SPX_OP_INDEX_INC = 4'hD;
   localparam logic [3:0] SPX_OP_INDEX_DEC = 4'hE;
   localparam logic [3:0] SPX_OP_ILLEGAL = 4'hF;
   // ==========================================================
   // Named byte locations
   localparam logic [5:0] SPX_LOC_H_UPPER = 6'h0A;
   localparam logic [5:0] SPX_LOC_H_LOWER = 6'h0B;
   localparam logic [5:0] SPX_LOC_K_UPPER = 6'h0C;
   localparam logic [5:0] SPX_LOC_K_LOWER = 6'h0D;
   localparam logic [5:0] SPX_LOC_Q_UPPER = 6'h0E;
   localparam logic [5:0] SPX_LOC_Q_LOWER = 6'h0F;
   // ==========================================================
   // Reset value and step constant
   localparam logic [5:0] SPX_INDEX_RESET = 6'h00;
   localparam logic [2:0] SPX_FIELD_ONE = 3'h1;
   // ==========================================================
   // Pair selection
   typedef enum logic [1:0] {
      SPX_PAIR_H,
      SPX_PAIR_K,
      SPX_PAIR_Q,
      SPX_PAIR_NONE
   } spx_pair_t;
endpackage

// ===== verilog/spx_ram.sv
/*
 Scratchpad byte store with one write port and two registered reads.
 Assumes the caller keeps addresses in range.
*/
`timescale 1ns/1ps
module spx_ram #(
   parameter int DATA_W = 8,
   parameter int ADDR_W = 6,
   parameter int DEPTH = 64
) (
   // Clock
   input wire logic clock,
   // Write port
   input wire logic wr_en,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [DATA_W-1:0] wr_data,
   // Read ports
   input wire logic [ADDR_W-1:0] rd_addr_a,
   output logic [DATA_W-1:0] rd_data_a,
   input wire logic [ADDR_W-1:0] rd_addr_b,
   output logic [DATA_W-1:0] rd_data_b
);
   logic [DATA_W-1:0] mem [DEPTH];

   always_ff @(posedge clock) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data_a <= mem[rd_addr_a];
      rd_data_b <= mem[rd_addr_b];
   end
endmodule

// ===== testbench/spx_dec_model.sv
/*
 Decode-side stand-in that issues byte, pair and index requests.
 Assumes one calling process; requests start and end on falling edges.
*/
`timescale 1ns/1ps
module spx_dec_model
   import spx_pkg::*;
(
   // Clock
   input wire logic clock,
   // Byte access
   output logic acc_en,
   output logic acc_write,
   output logic [3:0] acc_reg,
   output logic [7:0] acc_wdata,
   // Pair access
   output logic pair_en,
   output logic pair_write,
   output spx_pkg::spx_pair_t pair_sel,
   output logic [15:0] pair_wdata,
   // Index loads
   output logic index_load,
   output logic index_low_load,
   output logic index_high_load,
   output logic [5:0] index_wdata
);
   // ==========================================================
   // Requests
   initial begin
      {acc_en, acc_write, acc_reg, acc_wdata} = '0;
      {pair_en, pair_write, pair_wdata} = '0;
      pair_sel = SPX_PAIR_NONE;
      {index_load, index_low_load, index_high_load, index_wdata} = '0;
   end
   task automatic byte_op(input logic wr, input logic [3:0] r, input logic [7:0] d,
         input logic bad);
      // Only a refusal scenario may ask for the forbidden operand
      if (r == SPX_OP_ILLEGAL && !bad) return;
      @(negedge clock);
      acc_write = wr;
      acc_reg = r;
      acc_wdata = d;
      acc_en = 1'b1;
      @(negedge clock);
      acc_en = 1'b0;
      // Released data shows no stale value
      acc_wdata = ~d;
   endtask
   task automatic pair_op(input logic wr, input spx_pair_t s, input logic [15:0] d);
      @(negedge clock);
      pair_write = wr;
      pair_sel = s;
      pair_wdata = d;
      pair_en = 1'b1;
      @(negedge clock);
      pair_en = 1'b0;
      pair_wdata = ~d;
   endtask
   task automatic index_op(input logic [2:0] which, input logic [5:0] v);
      @(negedge clock);
      index_wdata = v;
      {index_load, index_low_load, index_high_load} = which;
      @(negedge clock);
      {index_load, index_low_load, index_high_load} = 3'h0;
      index_wdata = ~v;
   endtask
endmodule

// ===== testbench/spx_core_tb_top.sv
/*
 Self-checking bench for spx_core: table of byte accesses, then
 refusal, pair and reset cases. Assumes spx_dec_model drives requests.
*/
`timescale 1ns/1ps
module spx_core_tb_top;
   import spx_pkg::*;
   typedef struct packed {
      logic wr;
      logic [3:0] r;
      logic [7:0] d;
      logic [7:0] exp;
      logic [5:0] idx;
   } spx_row_t;
   logic clock, rst, acc_en, acc_write, acc_valid, acc_illegal;
   logic [3:0] acc_reg;
   logic [7:0] acc_wdata, acc_rdata;
   logic pair_en, pair_write, pair_valid;
   spx_pair_t pair_sel;
   logic [15:0] pair_wdata, pair_rdata, pd;
   logic index_load, index_low_load, index_high_load;
   logic [5:0] index_wdata, scratch_index_reg, loc;
   int num_errors = 0;
   int checks_done = 0;
   // ==========================================================
   // Byte table, index starts at 17
   spx_row_t rows [14] = '{
      '{1'b1, 4'h0, 8'h11, 8'h00, 6'h17}, '{1'b1, 4'hB, 8'h22, 8'h00, 6'h17},
      '{1'b1, 4'hC, 8'h33, 8'h00, 6'h17}, '{1'b1, 4'hD, 8'h44, 8'h00, 6'h10},
      '{1'b1, 4'hE, 8'h55, 8'h00, 6'h17}, '{1'b0, 4'hC, 8'h00, 8'h44, 6'h17},
      '{1'b0, 4'hE, 8'h00, 8'h44, 6'h16}, '{1'b1, 4'hD, 8'h66, 8'h00, 6'h17},
      '{1'b0, 4'hE, 8'h00, 8'h44, 6'h16}, '{1'b0, 4'hD, 8'h00, 8'h66, 6'h17},
      '{1'b0, 4'h0, 8'h00, 8'h11, 6'h17}, '{1'b0, 4'hB, 8'h00, 8'h22, 6'h17},
      '{1'b0, 4'hD, 8'h00, 8'h44, 6'h10}, '{1'b0, 4'hE, 8'h00, 8'h55, 6'h17}};
   spx_core #(.DATA_W(8)) dut (.clock, .rst, .acc_en, .acc_write, .acc_reg,
      .acc_wdata, .acc_rdata, .acc_valid, .acc_illegal, .pair_en, .pair_write,
      .pair_sel, .pair_wdata, .pair_rdata, .pair_valid, .index_load,
      .index_low_load, .index_high_load, .index_wdata, .scratch_index_reg);
   spx_dec_model u (.clock, .acc_en, .acc_write, .acc_reg, .acc_wdata, .pair_en,
      .pair_write, .pair_sel, .pair_wdata, .index_load, .index_low_load,
      .index_high_load, .index_wdata);
   // ==========================================================
   // Checking and verdict
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("Checks %0d, errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Run needs about 90 cycles
   initial begin
      repeat (3000) @(posedge clock);
      num_errors++;
      print_verdict();
   end
   // ==========================================================
   // Scenarios
   initial begin
      rst = 1'b1;
      repeat (10) @(negedge clock);
      check(16'(scratch_index_reg), 16'(SPX_INDEX_RESET), "index in reset");
      rst = 1'b0;
      u.index_op(3'h4, 6'h17);
      check(16'(scratch_index_reg), 16'h0017, "full load");
      u.index_op(3'h2, 6'h05);
      check(16'(scratch_index_reg), 16'h0015, "low load");
      u.index_op(3'h1, 6'h18);
      check(16'(scratch_index_reg), 16'h001D, "high load");
      u.index_op(3'h4, 6'h17);
      foreach (rows[i]) begin
         u.byte_op(rows[i].wr, rows[i].r, rows[i].d, 1'b0);
         check(16'(acc_valid), 16'(!rows[i].wr), "read answer");
         if (!rows[i].wr) check(16'(acc_rdata), 16'(rows[i].exp), "data");
         check(16'(scratch_index_reg), 16'(rows[i].idx), "step");
      end
      // Forbidden operand: flagged, no write, no step
      u.byte_op(1'b1, SPX_OP_ILLEGAL, 8'hAA, 1'b1);
      check(16'({acc_illegal, acc_valid}), 16'h0002, "refusal flag");
      check(16'(scratch_index_reg), 16'h0017, "no step");
      u.byte_op(1'b0, SPX_OP_INDEX, 8'h00, 1'b0);
      check(16'(acc_rdata), 16'h0044, "no write");
      for (int k = 0; k < 3; k++) begin
         pd = 16'hA150 + 16'(k * 16'h1101);
         loc = SPX_LOC_H_UPPER + 6'(2 * k);
         u.pair_op(1'b1, spx_pair_t'(2'(k)), pd);
         u.index_op(3'h4, loc);
         u.byte_op(1'b0, SPX_OP_INDEX_INC, 8'h00, 1'b0);
         check(16'(acc_rdata), 16'(pd[15:8]), "pair upper");
         u.byte_op(1'b0, SPX_OP_INDEX, 8'h00, 1'b0);
         check(16'(acc_rdata), 16'(pd[7:0]), "pair lower");
         u.byte_op(1'b1, SPX_OP_INDEX, 8'h5A, 1'b0);
         u.pair_op(1'b0, spx_pair_t'(2'(k)), 16'h0000);
         check(16'(pair_valid), 16'h0001, "pair answer");
         check(pair_rdata, {pd[15:8], 8'h5A}, "pair read");
      end
      u.pair_op(1'b0, SPX_PAIR_NONE, 16'h0000);
      check(16'(pair_valid), 16'h0000, "no pair");
      // Reset in mid-run
      rst = 1'b1;
      @(negedge clock);
      check(16'(scratch_index_reg), 16'(SPX_INDEX_RESET), "second reset");
      check(16'({acc_valid, acc_illegal, pair_valid}), 16'h0000, "pulses in reset");
      rst = 1'b0;
      // Store is not cleared by reset, so byte 0 still holds its earlier value
      u.byte_op(1'b0, SPX_OP_INDEX_INC, 8'h00, 1'b0);
      check(16'(acc_rdata), 16'h0011, "read after reset");
      check(16'(scratch_index_reg), 16'h0001, "step after reset");
      print_verdict();
   end
endmodule
